// file: adc_cfg_consts.svh
/*
 constants of the adc configuration and power register set: offsets, field positions, reset values.
 assumes inclusion by the register module and its testbench only.
*/
// Behaviour
// R01 - writing one to reset bit restores all config registers, bit then self-clears
// R02 - mapping field bits 7..5: 001 2-wire 18/14, 010 2-wire 16, 011 1-wire, 100 half
// R03 - new mapping value takes effect only after the fuse load command bit
// R04 - host writes interface register and fuse load first, before any other write
// R05 - after initial reset, fuse defaults for mode and mapping load automatically
// R06 - mapping and mode fields read 000 until written, fuse defaults still active
// R07 - override enable bit 3 gates mode select; when clear fuse mode stays active
// R08 - with override set, mode select 011 2-wire, 100 1-wire, 101 half-wire
// R09 - power-down bit 5 switches the sampling clock buffer off
// R10 - power-down bit 4 switches the reference gain amplifier off
// R11 - power-down bit 2 switches channel A off
// R12 - power-down bit 1 switches channel B off
// R13 - power-down bit 0 enters global power-down
// R14 - during global power-down the mask register picks which blocks switch off
// R15 - clock buffer mask bit set keeps the clock buffer awake in global sleep
// R16 - bandgap mask bit set lets the bandgap sleep in global power-down
// R17 - host writes zero to reserved bits; stored bits have no effect
`ifndef ADC_CFG_CONSTS_SVH
`define ADC_CFG_CONSTS_SVH

`define ADDR_SOFT_RESET 12'h000
`define ADDR_IF_SELECT 12'h007
`define ADDR_POWER_DOWN 12'h008
`define ADDR_SLEEP_MASK 12'h00D
`define ADDR_FUSE_LOAD 12'h013

`define RST_SOFT_RESET 8'h00
`define RST_IF_SELECT 8'h00
`define RST_POWER_DOWN 8'h00
`define RST_SLEEP_MASK 8'h00

`define POS_SOFT_RESET 0
`define POS_FUSE_LOAD 0
`define POS_MAP_HI 7
`define POS_MAP_LO 5
`define POS_OVERRIDE_EN 3
`define POS_MODE_HI 2
`define POS_MODE_LO 0
`define POS_CLKBUF_OFF 5
`define POS_REFAMP_OFF 4
`define POS_CHAN_A_OFF 2
`define POS_CHAN_B_OFF 1
`define POS_GLOBAL_SLEEP 0
`define POS_KEEP_CLKBUF 3
`define POS_KEEP_REFAMP 2
`define POS_BANDGAP_ALLOW 1

`define SER_ADDR_BITS 5'd16
`define SER_FRAME_BITS 5'd24

`define MAP_TWO_WIRE_WIDE 3'h1
`define MAP_TWO_WIRE_16 3'h2
`define MAP_ONE_WIRE 3'h3
`define MAP_HALF_WIRE 3'h4
`define MODE_TWO_WIRE 3'h3
`define MODE_ONE_WIRE 3'h4
`define MODE_HALF_WIRE 3'h5

`endif

// file: adc_cfg_pkg.sv
/*
 types of the adc configuration register set.
 assumes adc_cfg_consts.svh holds all numbers.
*/
package adc_cfg_pkg;
    typedef enum logic [2:0] {
        SER_IDLE = 3'b001,
        SER_ADDR = 3'b010,
        SER_DATA = 3'b100
    } ser_state_type;
endpackage

// file: adc_cfg_props.sv
/*
 checker of the adc config register ports.
 assumes one clock domain and static fuse pins.
*/
`timescale 1ns/1ns
module adc_cfg_props (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic serialEnable_n,
    input wire logic sdioOut,
    input wire logic sdioOe,
    input wire logic [2:0] fuseLaneMapping,
    input wire logic [2:0] fuseInterfaceMode,
    input wire logic [2:0] laneBitMapping,
    input wire logic [2:0] interfaceMode,
    input wire logic sampleClockBufferOff,
    input wire logic referenceAmpOff,
    input wire logic channelAOff,
    input wire logic channelBOff,
    input wire logic bandgapOff
);
    logic [3:0] idleCnt_r;
    logic [1:0] liveCnt_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // cycles since frame enable went high
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) idleCnt_r <= 4'hF;
        else if (!serialEnable_n) idleCnt_r <= 4'h0;
        else if (idleCnt_r != 4'hF) idleCnt_r <= idleCnt_r + 4'h1;
    end
    // cycles since reset release
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) liveCnt_r <= 2'h0;
        else if (liveCnt_r != 2'h3) liveCnt_r <= liveCnt_r + 2'h1;
    end
    chk_power_in_frame: assert property ($changed({sampleClockBufferOff, referenceAmpOff, channelAOff,
        channelBOff, bandgapOff}) |-> idleCnt_r < 4'hC) else $error("power output moved outside a frame");
    chk_sleep_chans: assert property (bandgapOff |-> channelAOff && channelBOff)
        else $error("bandgap off without global sleep");
    chk_oe_idle: assert property (idleCnt_r > 4'h6 |-> !sdioOe)
        else $error("sdio driven outside frame");
    chk_oe_frame: assert property ($rose(sdioOe) |-> idleCnt_r == 4'h0)
        else $error("sdio drive began outside frame");
    chk_mode_legal: assert property (liveCnt_r == 2'h3 |-> interfaceMode == fuseInterfaceMode
        || interfaceMode inside {3'h3, 3'h4, 3'h5}) else $error("illegal interface mode");
    chk_map_legal: assert property (liveCnt_r == 2'h3 |-> laneBitMapping == fuseLaneMapping
        || laneBitMapping inside {3'h1, 3'h2, 3'h3, 3'h4}) else $error("illegal lane mapping");
    chk_fuse_boot: assert property (liveCnt_r == 2'h2 |-> interfaceMode == fuseInterfaceMode
        && laneBitMapping == fuseLaneMapping && !channelAOff) else $error("fuse defaults not loaded");
    chk_data_frame: assert property ($changed(sdioOut) |-> idleCnt_r < 4'h8)
        else $error("readback moved outside frame");
endmodule
bind adc_config_power_regs adc_cfg_props u_props (.clk, .arst_n, .serialEnable_n, .sdioOut, .sdioOe,
    .fuseLaneMapping, .fuseInterfaceMode, .laneBitMapping, .interfaceMode, .sampleClockBufferOff,
    .referenceAmpOff, .channelAOff, .channelBOff, .bandgapOff);

// file: adc_config_power_regs.sv
/*
 configuration and power-down registers behind a three-wire serial programming port.
 assumes serial pins are asynchronous to clk and sclk runs well below clk/8;
 fuse values are static logic levels on clk.
*/
`timescale 1ns/1ns
`include "adc_cfg_consts.svh"
module adc_config_power_regs
    import adc_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic serialEnable_n,
    input wire logic serialClock,
    input wire logic sdioIn,
    output logic sdioOut,
    output logic sdioOe,
    input wire logic [2:0] fuseLaneMapping,
    input wire logic [2:0] fuseInterfaceMode,
    output logic [2:0] laneBitMapping,
    output logic [2:0] interfaceMode,
    output logic sampleClockBufferOff,
    output logic referenceAmpOff,
    output logic channelAOff,
    output logic channelBOff,
    output logic bandgapOff
);
    logic [1:0] senSync_r;
    logic [1:0] sclkSync_r;
    logic [1:0] sdioSync_r;
    logic sclkPrev_r;
    logic sclkRise;
    logic sclkFall;
    logic senActive;
    ser_state_type serState_r;
    logic [4:0] bitCnt_r;
    logic [23:0] shift_r;
    logic [15:0] cmd_r;
    logic [7:0] readShift_r;
    logic [15:0] cmdWord;
    logic wrStb_r;
    logic [11:0] wrAddr_r;
    logic [7:0] wrData_r;
    logic softReset_r;
    logic fuseLoad_r;
    logic fusePending_r;
    logic [7:0] ifSelect_r;
    logic [7:0] powerDown_r;
    logic [7:0] sleepMask_r;
    logic mapWritten_r;
    logic [2:0] fuseMap_r;
    logic [2:0] fuseMode_r;
    logic [2:0] activeMap_r;
    logic [2:0] modeSel;
    logic globalSleep;
    localparam int NUM_CHANNELS = 2;
    logic wrSoftReset;
    logic wrFuseLoad;
    logic wrIfSelect;
    logic wrPowerDown;
    logic wrSleepMask;
    logic [NUM_CHANNELS-1:0] chanBit;
    wire [NUM_CHANNELS-1:0] chanOff;

    function automatic logic [7:0] readMux(input logic [11:0] a);
        case (a)
            `ADDR_SOFT_RESET: readMux = {7'h00, softReset_r};
            `ADDR_IF_SELECT: readMux = ifSelect_r;
            `ADDR_POWER_DOWN: readMux = powerDown_r;
            `ADDR_SLEEP_MASK: readMux = sleepMask_r;
            `ADDR_FUSE_LOAD: readMux = {7'h00, fuseLoad_r};
            default: readMux = 8'h00;
        endcase
    endfunction

    // pin synchronisers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            senSync_r <= 2'h3;
            sclkSync_r <= 2'h0;
            sdioSync_r <= 2'h0;
            sclkPrev_r <= 1'b0;
        end else begin
            senSync_r <= {senSync_r[0], serialEnable_n};
            sclkSync_r <= {sclkSync_r[0], serialClock};
            sdioSync_r <= {sdioSync_r[0], sdioIn};
            sclkPrev_r <= sclkSync_r[1];
        end
    end

    assign senActive = ~senSync_r[1];
    assign sclkRise = sclkSync_r[1] & ~sclkPrev_r;
    assign sclkFall = ~sclkSync_r[1] & sclkPrev_r;
    assign cmdWord = {shift_r[14:0], sdioSync_r[1]};

    assign wrSoftReset = wrStb_r && wrAddr_r == `ADDR_SOFT_RESET;
    assign wrFuseLoad = wrStb_r && wrAddr_r == `ADDR_FUSE_LOAD;
    assign wrIfSelect = wrStb_r && wrAddr_r == `ADDR_IF_SELECT;
    assign wrPowerDown = wrStb_r && wrAddr_r == `ADDR_POWER_DOWN;
    assign wrSleepMask = wrStb_r && wrAddr_r == `ADDR_SLEEP_MASK;

    // serial frame: 16 address bits then 8 data bits
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            serState_r <= SER_IDLE;
            bitCnt_r <= 5'd0;
            shift_r <= 24'h000000;
            cmd_r <= 16'h0000;
        end else if (!senActive) begin
            serState_r <= SER_IDLE;
            bitCnt_r <= 5'd0;
        end else begin
            case (serState_r)
                SER_IDLE: begin
                    serState_r <= SER_ADDR;
                end
                SER_ADDR: begin
                    if (sclkRise) begin
                        shift_r <= {shift_r[22:0], sdioSync_r[1]};
                        bitCnt_r <= bitCnt_r + 5'd1;
                        if (bitCnt_r == `SER_ADDR_BITS - 5'd1) begin
                            cmd_r <= cmdWord;
                            serState_r <= SER_DATA;
                        end
                    end
                end
                SER_DATA: begin
                    if (sclkRise && bitCnt_r != `SER_FRAME_BITS) begin
                        shift_r <= {shift_r[22:0], sdioSync_r[1]};
                        bitCnt_r <= bitCnt_r + 5'd1;
                    end
                end
                default: begin
                    serState_r <= SER_IDLE;
                end
            endcase
        end
    end

    // write strobe after the 24th rising edge, reads block writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrStb_r <= 1'b0;
            wrAddr_r <= 12'h000;
            wrData_r <= 8'h00;
        end else begin
            wrStb_r <= 1'b0;
            if (senActive && serState_r == SER_DATA && sclkRise && bitCnt_r == `SER_FRAME_BITS - 5'd1
                && !cmd_r[15] && cmd_r[14:12] == 3'h0) begin
                wrStb_r <= 1'b1;
                wrAddr_r <= cmd_r[11:0];
                wrData_r <= {shift_r[6:0], sdioSync_r[1]};
            end
        end
    end

    // readback: launched on falling edges after the address
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            readShift_r <= 8'h00;
            sdioOut <= 1'b0;
            sdioOe <= 1'b0;
        end else begin
            if (senActive && serState_r == SER_ADDR && sclkRise && bitCnt_r == `SER_ADDR_BITS - 5'd1) begin
                readShift_r <= readMux(cmdWord[11:0]);
            end else if (senActive && serState_r == SER_DATA && cmd_r[15] && sclkFall) begin
                sdioOut <= readShift_r[7];
                readShift_r <= {readShift_r[6:0], 1'b0};
            end
            sdioOe <= senActive && serState_r == SER_DATA && cmd_r[15] && cmd_r[14:12] == 3'h0;
        end
    end

    // self-clearing soft reset command
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            softReset_r <= 1'b0;
        end else begin
            softReset_r <= wrSoftReset && wrData_r[`POS_SOFT_RESET]; // [R01]
        end
    end

    // self-clearing fuse load command
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fuseLoad_r <= 1'b0;
        end else begin
            fuseLoad_r <= wrFuseLoad && wrData_r[`POS_FUSE_LOAD]; // [R03]
        end
    end

    // interface select register, holds 000 until written
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ifSelect_r <= `RST_IF_SELECT; // [R06]
            mapWritten_r <= 1'b0;
        end else if (softReset_r) begin
            ifSelect_r <= `RST_IF_SELECT; // [R01]
            mapWritten_r <= 1'b0;
        end else if (wrIfSelect) begin
            ifSelect_r <= wrData_r; // [R17]
            mapWritten_r <= 1'b1;
        end
    end

    // power registers; fuse load discards earlier writes here
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            powerDown_r <= `RST_POWER_DOWN;
            sleepMask_r <= `RST_SLEEP_MASK;
        end else if (softReset_r || fuseLoad_r) begin
            powerDown_r <= `RST_POWER_DOWN; // [R01] [R04]
            sleepMask_r <= `RST_SLEEP_MASK;
        end else if (wrStb_r) begin
            if (wrPowerDown) begin
                powerDown_r <= wrData_r;
            end
            if (wrSleepMask) begin
                sleepMask_r <= wrData_r;
            end
        end
    end

    // fuse defaults captured after reset release and on each fuse load
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fusePending_r <= 1'b1;
            fuseMap_r <= 3'h0;
            fuseMode_r <= 3'h0;
        end else begin
            fusePending_r <= 1'b0;
            if (fusePending_r || fuseLoad_r) begin
                fuseMap_r <= fuseLaneMapping; // [R05]
                fuseMode_r <= fuseInterfaceMode;
            end
        end
    end

    // mapping applies only on fuse load; unused codes fall back to the fuse value
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            activeMap_r <= 3'h0;
        end else if (fusePending_r || softReset_r) begin
            activeMap_r <= fusePending_r ? fuseLaneMapping : fuseMap_r; // [R05]
        end else if (fuseLoad_r) begin
            if (mapWritten_r && ifSelect_r[`POS_MAP_HI:`POS_MAP_LO] >= `MAP_TWO_WIRE_WIDE
                && ifSelect_r[`POS_MAP_HI:`POS_MAP_LO] <= `MAP_HALF_WIRE) begin
                activeMap_r <= ifSelect_r[`POS_MAP_HI:`POS_MAP_LO]; // [R02] [R03]
            end else begin
                activeMap_r <= fuseLaneMapping;
            end
        end
    end

    always_comb begin
        modeSel = fuseMode_r; // [R07]
        if (ifSelect_r[`POS_OVERRIDE_EN]) begin
            case (ifSelect_r[`POS_MODE_HI:`POS_MODE_LO])
                `MODE_TWO_WIRE, `MODE_ONE_WIRE, `MODE_HALF_WIRE: modeSel = ifSelect_r[`POS_MODE_HI:`POS_MODE_LO]; // [R08]
                default: modeSel = fuseMode_r;
            endcase
        end
    end

    assign globalSleep = powerDown_r[`POS_GLOBAL_SLEEP]; // [R13]

    // registered interface outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            laneBitMapping <= 3'h0;
            interfaceMode <= 3'h0;
        end else begin
            laneBitMapping <= activeMap_r;
            interfaceMode <= modeSel;
        end
    end

    // registered shared block power outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sampleClockBufferOff <= 1'b0;
            referenceAmpOff <= 1'b0;
            bandgapOff <= 1'b0;
        end else begin
            sampleClockBufferOff <= powerDown_r[`POS_CLKBUF_OFF] // [R09]
                | (globalSleep & ~sleepMask_r[`POS_KEEP_CLKBUF]); // [R14] [R15]
            referenceAmpOff <= powerDown_r[`POS_REFAMP_OFF] // [R10]
                | (globalSleep & ~sleepMask_r[`POS_KEEP_REFAMP]); // [R14]
            bandgapOff <= globalSleep & sleepMask_r[`POS_BANDGAP_ALLOW]; // [R16]
        end
    end

    // per channel power outputs, index 0 is channel a
    assign chanBit = {powerDown_r[`POS_CHAN_B_OFF], powerDown_r[`POS_CHAN_A_OFF]}; // [R11] [R12]
    for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
        logic chanOff_r;
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                chanOff_r <= 1'b0;
            end else begin
                chanOff_r <= chanBit[ch] | globalSleep; // [R11] [R12] [R13]
            end
        end
        assign chanOff[ch] = chanOff_r;
    end
    assign channelAOff = chanOff[0];
    assign channelBOff = chanOff[1];
endmodule

// file: adc_host_model.sv
/*
 host controller model on the three-wire programming port.
 assumes clk is the device clock; serial clock half period is 6 clk.
*/
`timescale 1ns/1ns
module adc_host_model (
    input wire logic clk,
    input wire logic sdioOut,
    input wire logic sdioOe,
    output logic serialEnable_n,
    output logic serialClock,
    output logic sdioIn
);
    logic drv = 1'b0;
    logic bitOut = 1'b0;
    initial begin
        serialEnable_n = 1'b1;
        serialClock = 1'b0;
    end
    // released line shows inverse of last bit
    assign sdioIn = sdioOe ? sdioOut : (drv ? bitOut : ~bitOut);
    // one frame; task forces the three reserved command bits to zero
    task automatic xfer(input logic rd, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [23:0] f;
        f = {rd, 3'h0, a, d};
        q = 8'h00;
        @(posedge clk) serialEnable_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 23; i >= 0; i--) begin
            drv <= !(rd && i < 8);
            if (!(rd && i < 8)) bitOut <= f[i];
            repeat (6) @(posedge clk);
            serialClock <= 1'b1;
            if (rd && i < 8) q[i] = sdioIn;
            repeat (6) @(posedge clk);
            serialClock <= 1'b0;
        end
        repeat (6) @(posedge clk);
        serialEnable_n <= 1'b1;
        drv <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
endmodule

// file: tb_top.sv
/*
 testbench of the adc config and power registers.
 assumes the host model drives the serial port.
*/
`timescale 1ns/1ns
`include "adc_cfg_consts.svh"
module tb_top;
    localparam logic [2:0] FUSE_MAP = 3'h2;
    localparam logic [2:0] FUSE_MODE = 3'h4;
    logic [2:0] fuseMapPin = FUSE_MAP;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic serialEnable_n, serialClock, sdioIn, sdioOut, sdioOe;
    logic [2:0] laneBitMapping, interfaceMode, mc, expMode, curMap;
    logic sampleClockBufferOff, referenceAmpOff, channelAOff, channelBOff, bandgapOff;
    logic [7:0] q, offs;
    logic [7:0] pdIn [4] = '{8'h20, 8'h10, 8'h04, 8'h02};
    logic [7:0] pdOut [4] = '{8'h10, 8'h08, 8'h04, 8'h02};
    int errCount = 0;
    int samplesChecked = 0;
    int cycles = 0;
    always #4 clk = ~clk;
    assign offs = {3'h0, sampleClockBufferOff, referenceAmpOff, channelAOff, channelBOff, bandgapOff};
    adc_config_power_regs DUT (.clk(clk), .arst_n(arst_n), .serialEnable_n(serialEnable_n),
        .serialClock(serialClock), .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe),
        .fuseLaneMapping(fuseMapPin), .fuseInterfaceMode(FUSE_MODE), .laneBitMapping(laneBitMapping),
        .interfaceMode(interfaceMode), .sampleClockBufferOff(sampleClockBufferOff),
        .referenceAmpOff(referenceAmpOff), .channelAOff(channelAOff), .channelBOff(channelBOff),
        .bandgapOff(bandgapOff));
    adc_host_model host (.clk(clk), .sdioOut(sdioOut), .sdioOe(sdioOe), .serialEnable_n(serialEnable_n),
        .serialClock(serialClock), .sdioIn(sdioIn));
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errCount++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, q);
    endtask
    task rdchk(input string name, input logic [11:0] a, input logic [7:0] exp);
        host.xfer(1'b1, a, 8'h00, q);
        chk(name, exp, q);
    endtask
    task wrapUp;
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            errCount++;
            wrapUp();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        curMap = FUSE_MAP;
        chk("boot map", {5'h0, FUSE_MAP}, {5'h0, laneBitMapping});
        chk("boot mode", {5'h0, FUSE_MODE}, {5'h0, interfaceMode});
        rdchk("ifsel boot", `ADDR_IF_SELECT, `RST_IF_SELECT);
        rdchk("reset reg", `ADDR_SOFT_RESET, `RST_SOFT_RESET);
        rdchk("pdn boot", `ADDR_POWER_DOWN, `RST_POWER_DOWN);
        for (int m = 0; m < 5; m++) begin
            mc = m[2:0] + 3'h2;
            expMode = (mc >= 3'h3 && mc <= 3'h5) ? mc : FUSE_MODE;
            wr(`ADDR_IF_SELECT, {m[2:0], 2'b01, mc});
            chk("map held", {5'h0, curMap}, {5'h0, laneBitMapping});
            wr(`ADDR_FUSE_LOAD, 8'h01);
            curMap = (m >= 1) ? m[2:0] : FUSE_MAP;
            chk("map", {5'h0, curMap}, {5'h0, laneBitMapping});
            chk("mode", {5'h0, expMode}, {5'h0, interfaceMode});
            rdchk("ifsel", `ADDR_IF_SELECT, {m[2:0], 2'b01, mc});
        end
        wr(`ADDR_IF_SELECT, 8'h65);
        chk("mode no override", {5'h0, FUSE_MODE}, {5'h0, interfaceMode});
        chk("map no load", {5'h0, curMap}, {5'h0, laneBitMapping});
        for (int b = 0; b < 4; b++) begin
            wr(`ADDR_POWER_DOWN, pdIn[b]);
            chk("pdn out", pdOut[b], offs);
        end
        wr(`ADDR_POWER_DOWN, 8'hC8);
        chk("reserved out", 8'h00, offs);
        rdchk("reserved rd", `ADDR_POWER_DOWN, 8'hC8);
        wr(`ADDR_SLEEP_MASK, 8'h08);
        wr(`ADDR_POWER_DOWN, 8'h01);
        chk("sleep keep clk", 8'h0E, offs);
        wr(`ADDR_SLEEP_MASK, 8'h06);
        chk("sleep bandgap", 8'h17, offs);
        wr(12'h0FF, 8'h5A);
        rdchk("unmapped", 12'h0FF, 8'h00);
        wr(`ADDR_IF_SELECT, 8'h0B);
        chk("mode override", 8'h03, {5'h0, interfaceMode});
        wr(`ADDR_SOFT_RESET, 8'h01);
        chk("soft out", 8'h00, offs);
        chk("soft map", {5'h0, FUSE_MAP}, {5'h0, laneBitMapping});
        chk("soft mode", {5'h0, FUSE_MODE}, {5'h0, interfaceMode});
        rdchk("soft pdn", `ADDR_POWER_DOWN, 8'h00);
        rdchk("soft mask", `ADDR_SLEEP_MASK, 8'h00);
        rdchk("soft ifsel", `ADDR_IF_SELECT, 8'h00);
        rdchk("soft self clear", `ADDR_SOFT_RESET, 8'h00);
        fuseMapPin <= 3'h1;
        wr(`ADDR_FUSE_LOAD, 8'h01);
        chk("fuse reload map", 8'h01, {5'h0, laneBitMapping});
        wrapUp();
    end
endmodule
